// ==== rtl/dual_touch_probe_position_latch.sv ====
// two-channel touch-probe position latch with wishbone registers
// Summary of operation
// R1 - status word is a read-only 16-bit register, readable any time
// R2 - status bit 0 shows channel one enabled
// R3 - status bit 1 set while a rising-edge capture is held for channel one
// R4 - status bit 2 set while a falling-edge capture is held for channel one
// R5 - channel one continuous-mode capture count, two bits, wraps 3 to 0
// R6 - status bit 8 shows channel two enabled
// R7 - status bit 9 set while a rising-edge capture is held for channel two
// R8 - status bit 10 set while falling-edge capture is held for channel two
// R9 - status bits 14 and 15 count channel two continuous captures
// R10 - channel one rising capture held in read-only signed 32-bit register
// R11 - channel one falling capture held in its own signed 32-bit register
// R12 - channel two rising capture held in read-only signed 32-bit register
// R13 - channel two falling capture held in read-only signed 32-bit register
// R14 - input pin per channel selectable 0 to 2, applied only on restart
// R15 - filter time 0 to 1000 in 10 ns steps, applied at once
// R16 - control bits 0 and 8 enable the channels; no capture without them
// R17 - control bits 1 and 9: single first-event or continuous capture
// R18 - control bits 2 and 10 pick probe pin or encoder zero pulse
// R19 - control bits 4,5 and 12,13 enable rising and falling captures
// R20 - disabling a channel clears its held flags and its count
// R21 - probe pin changes must stay stable for the filter time to count
module dual_touch_probe_position_latch
  import probe_latch_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [probe_latch_pkg::NUM_PINS-1:0] probe_input_in,
  input wire logic encoder_zero_in,
  input wire logic [31:0] position_in
);
  import probe_latch_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic zero_meta;
    logic zero_sync;
    logic [NUM_PINS-1:0] pin_filt;
    logic [NUM_PINS-1:0][15:0] filt_cnt;
    logic [15:0] control;
    logic [15:0] pin_sel;
    logic [15:0] filt_time;
    logic [NUM_CH-1:0][1:0] pin_active;
    logic [NUM_CH-1:0] trig_prev;
    logic [NUM_CH-1:0] rise_held;
    logic [NUM_CH-1:0] fall_held;
    logic [NUM_CH-1:0][1:0] exec_count;
    logic [NUM_CH-1:0][31:0] rise_pos;
    logic [NUM_CH-1:0][31:0] fall_pos;
    logic ack;
    logic [31:0] rd_data;
  } state_t;

  state_t st;
  state_t next_st;

  logic [31:0] filt_product;
  logic [15:0] filt_cycles;
  logic bus_req;
  logic bus_write;
  logic [15:0] status_word;
  logic [15:0] wr_half;
  logic [NUM_CH-1:0] trig_level;
  logic [NUM_CH-1:0] ch_enabled;
  logic [NUM_CH-1:0] rise_event;
  logic [NUM_CH-1:0] fall_event;
  logic [NUM_CH-1:0] take_rise;
  logic [NUM_CH-1:0] take_fall;

  // filter time in clock cycles, rounded up
  always_comb begin
    filt_product = 32'(st.filt_time) * 32'(FILT_STEP_NS)
      + 32'(CLK_PERIOD_NS) - 32'h0000_0001;
    filt_cycles = 16'(filt_product / 32'(CLK_PERIOD_NS)); // R15
  end

  // status word assembled from channel state
  always_comb begin
    status_word = 16'h0000;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      status_word[ch * CH_BYTE_STRIDE + STAT_ENABLED] =
        st.control[ch * CH_BYTE_STRIDE + CTRL_ENABLE]; // R2 R6
      status_word[ch * CH_BYTE_STRIDE + STAT_RISE_HELD] =
        st.rise_held[ch]; // R3 R7
      status_word[ch * CH_BYTE_STRIDE + STAT_FALL_HELD] =
        st.fall_held[ch]; // R4 R8
      status_word[ch * CH_BYTE_STRIDE + STAT_COUNT_LSB +: 2] =
        st.exec_count[ch]; // R5 R9
    end
  end

  assign bus_req = wb_cyc_in & wb_stb_in;
  // a write lands on the edge where the master sees ack
  assign bus_write = bus_req & wb_we_in & st.ack;

  always_comb begin
    wr_half = wb_dat_in[15:0];
  end

  // trigger level and edge detection per channel
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      ch_enabled[ch] = st.control[ch * CH_BYTE_STRIDE + CTRL_ENABLE];
      if (st.control[ch * CH_BYTE_STRIDE + CTRL_SOURCE_ZERO]) begin
        trig_level[ch] = st.zero_sync; // R18
      end else begin
        trig_level[ch] = st.pin_filt[st.pin_active[ch]]; // R18
      end
      rise_event[ch] = ch_enabled[ch] & trig_level[ch]
        & ~st.trig_prev[ch];
      fall_event[ch] = ch_enabled[ch] & ~trig_level[ch]
        & st.trig_prev[ch];
      // single mode keeps only the first capture of each edge
      take_rise[ch] = rise_event[ch]
        & st.control[ch * CH_BYTE_STRIDE + CTRL_RISE_EN]
        & (st.control[ch * CH_BYTE_STRIDE + CTRL_CONTINUOUS]
           | ~st.rise_held[ch]); // R16 R17 R19
      take_fall[ch] = fall_event[ch]
        & st.control[ch * CH_BYTE_STRIDE + CTRL_FALL_EN]
        & (st.control[ch * CH_BYTE_STRIDE + CTRL_CONTINUOUS]
           | ~st.fall_held[ch]); // R16 R17 R19
    end
  end

  always_comb begin
    next_st = st;

    // two-stage synchronisers for pins and zero pulse
    next_st.pin_meta = probe_input_in;
    next_st.pin_sync = st.pin_meta;
    next_st.zero_meta = encoder_zero_in;
    next_st.zero_sync = st.zero_meta;

    // stability filter on each probe pin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (st.pin_sync[p] != st.pin_filt[p]) begin
        if (st.filt_cnt[p] + 16'h0001 >= filt_cycles) begin
          next_st.pin_filt[p] = st.pin_sync[p]; // R21
          next_st.filt_cnt[p] = 16'h0000;
        end else begin
          next_st.filt_cnt[p] = st.filt_cnt[p] + 16'h0001; // R21
        end
      end else begin
        next_st.filt_cnt[p] = 16'h0000; // R21
      end
    end

    // bus answer: one wait cycle, then ack for one cycle
    next_st.ack = bus_req & ~st.ack;
    if (bus_req & ~st.ack & ~wb_we_in) begin
      if (wb_adr_in == ADDR_CONTROL) begin
        next_st.rd_data = {16'h0000, st.control};
      end else if (wb_adr_in == ADDR_STATUS) begin
        next_st.rd_data = {16'h0000, status_word}; // R1
      end else if (wb_adr_in == ADDR_ONE_RISE) begin
        next_st.rd_data = st.rise_pos[0]; // R10
      end else if (wb_adr_in == ADDR_ONE_FALL) begin
        next_st.rd_data = st.fall_pos[0]; // R11
      end else if (wb_adr_in == ADDR_TWO_RISE) begin
        next_st.rd_data = st.rise_pos[1]; // R12
      end else if (wb_adr_in == ADDR_TWO_FALL) begin
        next_st.rd_data = st.fall_pos[1]; // R13
      end else if (wb_adr_in == ADDR_PIN_SEL) begin
        next_st.rd_data = {16'h0000, st.pin_sel};
      end else if (wb_adr_in == ADDR_FILT_TIME) begin
        next_st.rd_data = {16'h0000, st.filt_time};
      end else begin
        next_st.rd_data = 32'h0000_0000;
      end
    end else begin
      next_st.rd_data = 32'h0000_0000;
    end

    // register writes; read-only and unmapped writes are ignored
    if (bus_write) begin
      if (wb_adr_in == ADDR_CONTROL) begin
        if (wb_sel_in[0]) begin
          next_st.control[7:0] = wr_half[7:0]; // R16
        end
        if (wb_sel_in[1]) begin
          next_st.control[15:8] = wr_half[15:8]; // R16
        end
      end else if (wb_adr_in == ADDR_PIN_SEL) begin
        if (wb_sel_in[0]) begin
          for (int ch = 0; ch < NUM_CH; ch++) begin
            if (wr_half[ch * PIN_SEL_NIBBLE +: PIN_SEL_NIBBLE]
                <= 4'(PIN_SEL_MAX)) begin
              next_st.pin_sel[ch * PIN_SEL_NIBBLE +: PIN_SEL_NIBBLE] =
                wr_half[ch * PIN_SEL_NIBBLE +: PIN_SEL_NIBBLE]; // R14
            end
          end
        end
        // restart request: apply the stored pin choice
        if (wb_sel_in[1] & wr_half[PIN_SEL_APPLY]) begin
          for (int ch = 0; ch < NUM_CH; ch++) begin
            next_st.pin_active[ch] =
              next_st.pin_sel[ch * PIN_SEL_NIBBLE +: 2]; // R14
          end
        end
      end else if (wb_adr_in == ADDR_FILT_TIME) begin
        if ((wb_sel_in[1:0] == 2'h3) & (wr_half <= FILT_TIME_MAX)) begin
          next_st.filt_time = wr_half; // R15
        end
      end
    end

    // capture logic per channel
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_st.trig_prev[ch] = trig_level[ch];
      if (take_rise[ch]) begin
        next_st.rise_pos[ch] = position_in; // R10 R12
        next_st.rise_held[ch] = 1'b1; // R3 R7
      end
      if (take_fall[ch]) begin
        next_st.fall_pos[ch] = position_in; // R11 R13
        next_st.fall_held[ch] = 1'b1; // R4 R8
      end
      if ((take_rise[ch] | take_fall[ch])
          & st.control[ch * CH_BYTE_STRIDE + CTRL_CONTINUOUS]) begin
        next_st.exec_count[ch] = st.exec_count[ch] + 2'h1; // R5 R9
      end
      // a disabled channel starts empty when enabled again
      if (!next_st.control[ch * CH_BYTE_STRIDE + CTRL_ENABLE]) begin
        next_st.rise_held[ch] = 1'b0; // R20
        next_st.fall_held[ch] = 1'b0; // R20
        next_st.exec_count[ch] = 2'h0; // R20
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
      st.control <= CONTROL_RESET;
      st.pin_sel <= PIN_SEL_RESET; // R14
      st.filt_time <= FILT_TIME_RESET; // R15
      st.pin_active[0] <= PIN_ONE_RESET; // R14
      st.pin_active[1] <= PIN_TWO_RESET; // R14
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_out = st.rd_data;
  assign wb_ack_out = st.ack;

endmodule

// ==== rtl/probe_latch_pkg.sv ====
// constants shared by the dual touch-probe position latch
package probe_latch_pkg;

  // clock and filter timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FILT_STEP_NS = 10;
  localparam logic [15:0] FILT_TIME_MAX = 16'h03e8;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'h60b8;
  localparam logic [15:0] IDX_STATUS = 16'h60b9;
  localparam logic [15:0] IDX_ONE_RISE = 16'h60ba;
  localparam logic [15:0] IDX_ONE_FALL = 16'h60bb;
  localparam logic [15:0] IDX_TWO_RISE = 16'h60bc;
  localparam logic [15:0] IDX_TWO_FALL = 16'h60bd;
  localparam logic [15:0] IDX_PIN_SEL = 16'h60c0;
  localparam logic [15:0] IDX_FILT_TIME = 16'h60c1;

  localparam logic [31:0] ADDR_CONTROL = {14'h0000, IDX_CONTROL, 2'b00};
  localparam logic [31:0] ADDR_STATUS = {14'h0000, IDX_STATUS, 2'b00};
  localparam logic [31:0] ADDR_ONE_RISE = {14'h0000, IDX_ONE_RISE, 2'b00};
  localparam logic [31:0] ADDR_ONE_FALL = {14'h0000, IDX_ONE_FALL, 2'b00};
  localparam logic [31:0] ADDR_TWO_RISE = {14'h0000, IDX_TWO_RISE, 2'b00};
  localparam logic [31:0] ADDR_TWO_FALL = {14'h0000, IDX_TWO_FALL, 2'b00};
  localparam logic [31:0] ADDR_PIN_SEL = {14'h0000, IDX_PIN_SEL, 2'b00};
  localparam logic [31:0] ADDR_FILT_TIME = {14'h0000, IDX_FILT_TIME, 2'b00};

  // per-channel field layout, channel two sits one byte higher
  localparam int CH_BYTE_STRIDE = 8;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CONTINUOUS = 1;
  localparam int CTRL_SOURCE_ZERO = 2;
  localparam int CTRL_RISE_EN = 4;
  localparam int CTRL_FALL_EN = 5;
  localparam int STAT_ENABLED = 0;
  localparam int STAT_RISE_HELD = 1;
  localparam int STAT_FALL_HELD = 2;
  localparam int STAT_COUNT_LSB = 6;

  // pin selection: one nibble per channel, bit 15 reapplies it
  localparam int PIN_SEL_NIBBLE = 4;
  localparam int PIN_SEL_APPLY = 15;
  localparam logic [1:0] PIN_SEL_MAX = 2'h2;
  localparam logic [1:0] PIN_ONE_RESET = 2'h0;
  localparam logic [1:0] PIN_TWO_RESET = 2'h1;
  localparam logic [15:0] PIN_SEL_RESET = 16'h0010;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FILT_TIME_RESET = 16'h0000;

  localparam int NUM_PINS = 3;
  localparam int NUM_CH = 2;

endpackage

// ==== verif/dual_touch_probe_position_latch_tb_top.sv ====
// self-checking bench for the touch-probe latch
module dual_touch_probe_position_latch_tb_top
  import probe_latch_pkg::*;
;
  timeunit 1ns / 100ps;
  logic clk = 1'h0, rst = 1'h1, req = 1'h0, we = 1'h0, zero = 1'h0;
  logic ack, zpin;
  logic [31:0] adr = 32'h0, wdat = 32'h0, pos = 32'h0, rdat, position;
  logic [2:0] pins = 3'h0, probe;
  logic [3:0] sel = 4'h3;
  int mismatches = 0, compares = 0;
  always #12.5 clk = ~clk;
  probe_source src_u (.pin_in(pins), .zero_in(zero), .pos_in(pos),
    .probe_out(probe), .zero_out(zpin), .position_out(position));
  dual_touch_probe_position_latch dut_u (
    .core_clk_in(clk), .reset_in(rst), .wb_cyc_in(req), .wb_stb_in(req),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .probe_input_in(probe),
    .encoder_zero_in(zpin), .position_in(position));
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d);
    req <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    repeat (50) if (ack !== 1'h1) @(posedge clk);
    if (ack !== 1'h1) mismatches++;
    if (!w) chk(rdat, d);
    req <= 1'h0;
    @(posedge clk);
  endtask
  task automatic drive(input logic [2:0] p, input logic z,
      input logic [31:0] v, input int n);
    pins <= p;
    zero <= z;
    pos <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_single;
    wb(1'h0, ADDR_PIN_SEL, 32'h10);
    drive(3'h1, 1'h0, 32'h5, 12);
    wb(1'h0, ADDR_STATUS, 32'h0);
    wb(1'h1, ADDR_CONTROL, 32'h31);
    drive(3'h0, 1'h0, 32'hfffffff0, 12);
    drive(3'h1, 1'h0, 32'h1111, 12);
    drive(3'h0, 1'h0, 32'h2222, 12);
    wb(1'h0, ADDR_STATUS, 32'h7);
    wb(1'h0, ADDR_ONE_FALL, 32'hfffffff0);
    wb(1'h0, ADDR_ONE_RISE, 32'h1111);
  endtask
  task automatic t_cont;
    wb(1'h1, ADDR_CONTROL, 32'h0);
    wb(1'h1, ADDR_CONTROL, 32'h3717);
    wb(1'h0, ADDR_STATUS, 32'h101);
    for (int i = 1; i < 4; i++) begin
      drive(pins, 1'h1, 32'h100 * i, 3);
      drive(pins, 1'h0, 32'h100 * i, 8);
      if (i == 2) wb(1'h0, ADDR_STATUS, 32'h783);
    end
    wb(1'h0, ADDR_STATUS, 32'h87c3);
    wb(1'h0, ADDR_TWO_FALL, 32'h300);
    wb(1'h0, ADDR_TWO_RISE, 32'h300);
    wb(1'h1, ADDR_CONTROL, 32'h0);
    wb(1'h0, ADDR_STATUS, 32'h0);
  endtask
  task automatic t_filter;
    wb(1'h1, ADDR_FILT_TIME, 32'h3e8);
    wb(1'h1, ADDR_FILT_TIME, 32'h3e9);
    wb(1'h0, ADDR_FILT_TIME, 32'h3e8);
    wb(1'h1, ADDR_CONTROL, 32'h13);
    drive(3'h1, 1'h0, 32'h8, 300);
    drive(3'h0, 1'h0, 32'h8, 300);
    wb(1'h0, ADDR_STATUS, 32'h1);
    drive(3'h1, 1'h0, 32'h9, 440);
    wb(1'h0, ADDR_ONE_RISE, 32'h9);
  endtask
  // pin choice applied by the restart bit, out-of-range nibbles rejected
  task automatic t_pins;
    wb(1'h1, ADDR_FILT_TIME, 32'h0);
    wb(1'h1, ADDR_CONTROL, 32'h0);
    wb(1'h1, ADDR_PIN_SEL, 32'h8002);
    wb(1'h1, ADDR_PIN_SEL, 32'h33);
    wb(1'h0, ADDR_PIN_SEL, 32'h2);
    wb(1'h1, ADDR_CONTROL, 32'h1111);
    drive(3'h4, 1'h0, 32'h44, 8);
    drive(3'h5, 1'h0, 32'h55, 8);
    wb(1'h0, ADDR_ONE_RISE, 32'h44);
    wb(1'h0, ADDR_TWO_RISE, 32'h55);
    wb(1'h0, ADDR_STATUS, 32'h303);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_single;
    t_cont;
    t_filter;
    t_pins;
    wrap_up;
  end
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule

// ==== verif/probe_latch_checker.sv ====
// bus and status checks for the touch-probe latch
module probe_latch_checker
  import probe_latch_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out
);
  timeunit 1ns / 100ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire logic rd = wb_ack_out && !wb_we_in;
  wire logic [31:0] d = wb_dat_out;
  AST_ACK_NEXT: assert property (wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("late ack");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("long ack");
  AST_IDLE: assert property (!wb_ack_out |-> d == 32'h0)
    else $error("idle data");
  AST_ACK_SRC: assert property ($rose(wb_ack_out)
    |-> $past(wb_stb_in)) else $error("stray ack");
  AST_RSVD: assert property (rd && wb_adr_in == ADDR_STATUS
    |-> d[31:16] == 16'h0 && d[5:3] == 3'h0 && d[13:11] == 3'h0)
    else $error("reserved set");
  AST_ONE_CLR: assert property (rd && wb_adr_in == ADDR_STATUS
    && !d[0] |-> d[2:1] == 2'h0 && d[7:6] == 2'h0) else $error("one held");
  AST_TWO_CLR: assert property (rd && wb_adr_in == ADDR_STATUS
    && !d[8] |-> d[10:9] == 2'h0 && d[15:14] == 2'h0) else $error("two held");
  AST_PIN: assert property (rd && wb_adr_in == ADDR_PIN_SEL
    |-> d[3:0] <= 4'h2 && d[7:4] <= 4'h2) else $error("pin range");
  AST_FILT: assert property (rd && wb_adr_in == ADDR_FILT_TIME
    |-> d[15:0] <= FILT_TIME_MAX) else $error("filter range");
endmodule
bind dual_touch_probe_position_latch probe_latch_checker chk_u (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out));

// ==== verif/probe_source.sv ====
// probe pins, zero pulse and feedback position seen by the drive
module probe_source (
  input wire logic [2:0] pin_in,
  input wire logic zero_in,
  input wire logic [31:0] pos_in,
  output logic [2:0] probe_out,
  output logic zero_out,
  output logic [31:0] position_out
);
  timeunit 1ns / 100ps;
  assign probe_out = pin_in;
  assign zero_out = zero_in;
  assign position_out = pos_in;
endmodule
